// ### hdl/flash_signature_security_gate.sv
// Command gate of the serial flash-programming interface: signature stream,
// security flags and the erase/write/release checks, with AHB-Lite registers.
// Assumes a zero-wait AHB-Lite master, blank flags and option byte from logic
// on clk_sys, and por_n asserted only to model the factory-fresh flash.
`timescale 1ns/100ps
`default_nettype none

module flash_signature_security_gate
  import flash_gate_pkg::*;
#(
  parameter logic [23:0] DEV_CODE  = 24'h5a5a5a,  // Arbitrary value
  parameter logic [79:0] DEV_NAME  = 80'h464c4153484741544520,
  parameter logic [23:0] CODE_LAST = 24'h003fff,
  parameter logic [23:0] DATA_LAST = 24'h0f17ff,
  parameter logic [23:0] FW_VER    = 24'h010203
)
(
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          por_n,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output var  logic          hreadyout,
  output var  logic [31:0]   hrdata,
  output var  logic          hresp,
  input  wire logic [7:0]    opt_byte,
  input  wire logic          code_blank,
  input  wire logic          data_blank,
  input  wire logic          sp_erase_req,
  input  wire logic          sp_write_req,
  input  wire sec_flags_type sp_set,
  output var  flash_op_type  flash_op,
  output var  sec_flags_type sec_state,
  output var  logic          rel_pending,
  output var  logic          full_speed,
  output var  logic          irq
);

  // Addresses are 20 bits wide in the flash map
  if (CODE_LAST > 24'h0fffff || DATA_LAST > 24'h0fffff)
  begin : g_bad_addr
    $error("flash last address exceeds 20 bits");
  end

  wire flash_speed_cfg_hi = opt_byte[CFG_HI_BIT];
  wire flash_speed_cfg_lo = opt_byte[CFG_LO_BIT];

  logic                 wr_dp_r;
  logic [7:0]           wa_r;
  logic                 ack_r;
  logic                 nak_r;
  logic                 sig_active_r;
  logic [4:0]           sig_idx_r;
  logic [4:0]           sig_idx_nxt;
  logic                 ctrl_fs_r;
  logic [NUM_EV-1:0]    ista_r;
  logic [NUM_EV-1:0]    ista_nxt;
  logic [NUM_EV-1:0]    ien_r;
  logic                 booted_r;
  sec_flags_type        sec_r;
  sec_flags_type        sec_nxt;
  logic                 rel_pend_r;
  logic [31:0]          rd_mux;

  // Bus address phase; the slave never stalls so hsel, htrans[1] and hready qualify it
  wire       addr_ok  = hsel & htrans[1] & hready;
  wire       wr_ap    = addr_ok & hwrite;
  wire       rd_ap    = addr_ok & ~hwrite;
  wire [7:0] ra       = haddr[7:0];
  wire       wr_cmd   = wr_dp_r & (wa_r == ADDR_CMD);
  wire       wr_ctrl  = wr_dp_r & (wa_r == ADDR_CTRL);
  wire       wr_iclr  = wr_dp_r & (wa_r == ADDR_ICLR);
  wire       wr_ien   = wr_dp_r & (wa_r == ADDR_IEN);
  wire [3:0] op       = hwdata[OP_LSB +: 4];

  // Command decode
  wire is_sig   = (op == OP_SIG);
  wire is_erase = (op == OP_ERASE);
  wire is_write = (op == OP_WRITE);
  wire is_set   = (op == OP_SET);
  wire is_rel   = (op == OP_REL);
  wire is_get   = (op == OP_GET);

  // Security checks on link commands
  wire erase_ok = ~sec_r.erase_prohib;
  wire write_ok = ~sec_r.write_prohib;
  wire rel_ok   = ~sec_r.erase_prohib & code_blank & data_blank;
  wire cmd_good = is_sig | is_get | is_set | (is_erase & erase_ok)
                | (is_write & write_ok) | (is_rel & rel_ok);
  wire cmd_ack  = wr_cmd & cmd_good;
  wire cmd_nak  = wr_cmd & ~cmd_good;
  wire link_erase = cmd_ack & is_erase;
  wire link_write = cmd_ack & is_write;
  wire rel_acc    = cmd_ack & is_rel;
  wire set_ep     = cmd_ack & is_set & hwdata[SET_EP_BIT];
  wire set_wp     = cmd_ack & is_set & hwdata[SET_WP_BIT];

  // A pending release is applied on the first clock after a device reset
  wire apply_rel = ~booted_r & rel_pend_r;

  // Flags only ever set, except write prohibition on an applied release;
  // a set arriving together with the release wins
  assign sec_nxt.erase_prohib = sec_r.erase_prohib | set_ep | sp_set.erase_prohib;
  assign sec_nxt.write_prohib = (sec_r.write_prohib & ~apply_rel)
                              | set_wp | sp_set.write_prohib;

  // Signature byte stream in send order
  wire [SIG_BITS-1:0] sig_vec = {
    DEV_CODE, DEV_NAME,
    CODE_LAST[7:0], CODE_LAST[15:8], CODE_LAST[23:16],
    DATA_LAST[7:0], DATA_LAST[15:8], DATA_LAST[23:16],
    FW_VER[23:16], FW_VER[15:8], FW_VER[7:0]
  };
  wire [7:0] sig_base = 8'(SIG_BITS - 1) - {sig_idx_r, 3'b000};
  wire [7:0] sig_byte = sig_vec[sig_base -: 8];
  wire       sig_pop  = rd_ap & (ra == ADDR_SIG) & sig_active_r;
  wire       sig_last = (sig_idx_r == 5'(SIG_BYTES - 1));
  wire       sig_go   = cmd_ack & is_sig;

  // Restart wins over a pop in the same cycle
  assign sig_idx_nxt = sig_go ? 5'h00 : (sig_pop ? sig_idx_r + 5'h01 : sig_idx_r);

  // Interrupt status: a new event wins over a clear of the same bit
  wire [NUM_EV-1:0] ev = {sig_pop & sig_last, cmd_nak, cmd_ack};
  assign ista_nxt = (ista_r & ~(wr_iclr ? hwdata[NUM_EV-1:0] : '0)) | ev;

  // Read data, sampled in the address phase and held through the data phase
  assign rd_mux =
      (ra == ADDR_RESP) ? {30'h0, nak_r, ack_r} :
      (ra == ADDR_SIG)  ? {23'h0, sig_active_r, sig_active_r ? sig_byte : 8'h00} :
      (ra == ADDR_SEC)  ? {28'h0, full_speed, rel_pend_r, sec_r.write_prohib,
                           sec_r.erase_prohib} :
      (ra == ADDR_CTRL) ? {31'h0, ctrl_fs_r} :
      (ra == ADDR_ISTA) ? {29'h0, ista_r} :
      (ra == ADDR_IEN)  ? {29'h0, ien_r} : 32'h0;

  // Nonvolatile security state, reset only by the factory-fresh reset; an applied release clears write prohibition
  always_ff @(posedge clk_sys or negedge por_n)
  begin
    if (!por_n)
    begin
      sec_r      <= SEC_SHIPPED;
      rel_pend_r <= 1'b0;
    end
    else
    begin
      sec_r      <= sec_nxt;
      rel_pend_r <= (rel_pend_r & ~apply_rel) | rel_acc;
    end
  end

  // Bus pipeline and answer registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_dp_r   <= 1'b0;
      wa_r      <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      ack_r     <= 1'b0;
      nak_r     <= 1'b0;
    end
    else
    begin
      wr_dp_r   <= wr_ap;
      wa_r      <= ra;
      hrdata    <= rd_ap ? rd_mux : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ack_r     <= wr_cmd ? cmd_ack : ack_r;
      nak_r     <= wr_cmd ? cmd_nak : nak_r;
    end
  end

  // Signature walk, control, interrupts and flash strobes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      booted_r     <= 1'b0;
      sig_active_r <= 1'b0;
      sig_idx_r    <= 5'h00;
      ctrl_fs_r    <= CTRL_RST;
      ista_r       <= '0;
      ien_r        <= IEN_RST;
      irq          <= 1'b0;
      full_speed   <= 1'b0;
      flash_op     <= '0;
      sec_state    <= SEC_SHIPPED;
      rel_pending  <= 1'b0;
    end
    else
    begin
      booted_r     <= 1'b1;
      sig_active_r <= sig_go | (sig_active_r & ~(sig_pop & sig_last));
      sig_idx_r    <= sig_idx_nxt;
      ctrl_fs_r    <= wr_ctrl ? hwdata[0] : ctrl_fs_r;
      ista_r       <= ista_nxt;
      ien_r        <= wr_ien ? hwdata[NUM_EV-1:0] : ien_r;
      irq          <= |(ista_nxt & ien_r);
      full_speed   <= ctrl_fs_r & flash_speed_cfg_hi & flash_speed_cfg_lo;
      // Self-programming bypasses the link security checks
      flash_op.erase <= link_erase | sp_erase_req;
      flash_op.write <= link_write | sp_write_req;
      sec_state    <= sec_nxt;
      rel_pending  <= (rel_pend_r & ~apply_rel) | rel_acc;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !por_n);

  sequence s_pop(int n);
    sig_pop && sig_idx_r == 5'(n);
  endsequence

  // Exactly one answer, and its status bit is up
  sequence s_answer;
    ack_r != nak_r && (ack_r ? ista_r[EV_ACK] : ista_r[EV_NAK]);
  endsequence

  a_sig_devcode: assert property (s_pop(0) |=> hrdata[7:0] == DEV_CODE[23:16])
    else $error("signature does not open with device code");
  a_sig_codeaddr: assert property (s_pop(13) |=> hrdata[7:0] == CODE_LAST[7:0])
    else $error("code last address not low byte first");
  a_sig_dataaddr: assert property (s_pop(16) |=> hrdata[7:0] == DATA_LAST[7:0])
    else $error("data last address not low byte first");
  a_sig_fwver: assert property (s_pop(19) |=> hrdata[7:0] == FW_VER[23:16])
    else $error("firmware digits out of order");
  a_erase_refused: assert property (wr_cmd && is_erase && sec_r.erase_prohib
      && !sp_erase_req |=> !flash_op.erase && nak_r)
    else $error("erase passed under erase prohibition");
  a_write_refused: assert property (wr_cmd && is_write && sec_r.write_prohib
      && !sp_write_req |=> !flash_op.write && nak_r)
    else $error("write passed under write prohibition");
  a_release_defer: assert property (booted_r && sec_r.write_prohib |=> sec_r.write_prohib)
    else $error("write prohibition cleared without reset");
  a_ep_sticky: assert property (sec_r.erase_prohib |=> sec_r.erase_prohib)
    else $error("erase prohibition cleared");
  a_release_gate: assert property (wr_cmd && is_rel && !rel_ok
      |=> nak_r && !ack_r && $stable(rel_pend_r))
    else $error("release accepted without its conditions");
  a_full_speed: assert property (full_speed |-> $past(flash_speed_cfg_hi && flash_speed_cfg_lo))
    else $error("full speed without both option bits");
  a_every_reply: assert property (wr_cmd |=> s_answer)
    else $error("command left without single answer");

endmodule // flash_signature_security_gate

`default_nettype wire

// ### hdl/flash_gate_pkg.sv
// Constants, register map and carrier types of the flash signature/security gate.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.
package flash_gate_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CMD  = 8'h00;
  localparam logic [7:0] ADDR_RESP = 8'h04;
  localparam logic [7:0] ADDR_SIG  = 8'h08;
  localparam logic [7:0] ADDR_SEC  = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_ISTA = 8'h14;
  localparam logic [7:0] ADDR_ICLR = 8'h18;
  localparam logic [7:0] ADDR_IEN  = 8'h1c;
  // Command opcodes in CMD[3:0]
  localparam logic [3:0] OP_SIG   = 4'h1;
  localparam logic [3:0] OP_ERASE = 4'h2;
  localparam logic [3:0] OP_WRITE = 4'h3;
  localparam logic [3:0] OP_SET   = 4'h4;
  localparam logic [3:0] OP_REL   = 4'h5;
  localparam logic [3:0] OP_GET   = 4'h6;
  // Field positions
  localparam int OP_LSB     = 0;
  localparam int SET_EP_BIT = 8;
  localparam int SET_WP_BIT = 9;
  localparam int CFG_HI_BIT = 1;
  localparam int CFG_LO_BIT = 0;
  localparam int EV_ACK     = 0;
  localparam int EV_NAK     = 1;
  localparam int EV_SIGEND  = 2;
  localparam int NUM_EV     = 3;
  // Signature layout
  localparam int SIG_BYTES  = 22;
  localparam int SIG_BITS   = SIG_BYTES * 8;
  // Reset values
  localparam logic [NUM_EV-1:0] IEN_RST  = 3'h0;
  localparam logic              CTRL_RST = 1'b0;

  // Security flags, also the shape of their set requests
  typedef struct packed {
    logic write_prohib;
    logic erase_prohib;
  } sec_flags_type;

  localparam sec_flags_type SEC_SHIPPED = 2'h0;

  // One-cycle launch strobes toward the flash sequencer
  typedef struct packed {
    logic write;
    logic erase;
  } flash_op_type;
endpackage

// ### sim/flash_prog_model.sv
// Programmer-side model: issues single-word AHB-Lite transfers to the gate.
// Assumes hready is fed back from the gate's hreadyout by the testbench.
`timescale 1ns/100ps
`default_nettype none
module flash_prog_model
(
  input  wire logic        clk_sys,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  // Bus idles with no transfer pending
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; the next one only starts once this answer is in
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
endmodule // flash_prog_model
`default_nettype wire

// ### sim/tb_flash_signature_security_gate.sv
// Self-checking bench of the signature/security gate through its registers.
// Assumes the programmer model drives the bus; flash status lines come from here.
`timescale 1ns/100ps
`default_nettype none
module tb_flash_signature_security_gate;
  import flash_gate_pkg::*;
  localparam logic [23:0]  DEVC  = 24'h3c3c3c; // Arbitrary value
  localparam logic [79:0]  NAME  = 80'h30313233343536373839;
  localparam logic [23:0]  CLAST = 24'h003fff;
  localparam logic [23:0]  DLAST = 24'h0f17ff;
  localparam logic [23:0]  FWV   = 24'h010203;
  localparam logic [175:0] SIG   = {DEVC, NAME, CLAST[7:0], CLAST[15:8], CLAST[23:16],
                                    DLAST[7:0], DLAST[15:8], DLAST[23:16], FWV};
  logic          clk_sys, rst_n, por_n, hsel, hwrite, hreadyout, hresp;
  localparam int   OSC_WAIT = 7500; // 30 us of 4 ns cycles
  logic          rel_pending, full_speed, irq, code_blank, data_blank, sp_write_req;
  logic          sp_erase_req;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [7:0]    opt_byte;
  logic [31:0]   haddr, hwdata, hrdata, seen;
  logic [31:0]   exp_q[$];
  sec_flags_type sp_set, sec_state;
  flash_op_type  flash_op;
  int            fails, tests_run, seed, wcnt, ecnt;
  event          got_ev;

  flash_prog_model prog (.clk_sys(clk_sys), .hreadyout(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  flash_signature_security_gate #(.DEV_CODE(DEVC), .DEV_NAME(NAME), .CODE_LAST(CLAST),
    .DATA_LAST(DLAST), .FW_VER(FWV)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .opt_byte(opt_byte), .code_blank(code_blank),
    .data_blank(data_blank), .sp_erase_req(sp_erase_req), .sp_write_req(sp_write_req),
    .sp_set(sp_set), .flash_op(flash_op), .sec_state(sec_state),
    .rel_pending(rel_pending), .full_speed(full_speed), .irq(irq));

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic conclude;
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Note the expectation, read, then hand the result to the watcher
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    exp_q.push_back(e);
    prog.xfer({24'h0, a}, 1'b0, 32'h0, d);
    seen = d;
    -> got_ev;
  endtask

  // Two idle edges so the result is settled before the next address phase
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    prog.xfer({24'h0, a}, 1'b1, d, x);
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic cmd_resp(input logic [31:0] c, input logic [31:0] e);
    wr(ADDR_CMD, c);
    rd_exp(ADDR_RESP, e);
  endtask

  task automatic dev_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Watcher pairs every read result with the oldest note
  initial
    forever
    begin
      @(got_ev);
      check(seen, exp_q.pop_front());
    end

  // Launch pulses counted to prove refused commands touch no flash
  always @(posedge clk_sys)
  begin
    if (flash_op.write === 1'b1) wcnt++;
    if (flash_op.erase === 1'b1) ecnt++;
  end

  // Hang guard; the sequence needs about eight thousand cycles, mostly oscillator wait
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end

  initial
  begin
    seed = 50507;
    {rst_n, por_n, sp_write_req, sp_erase_req} = 4'h0;
    {code_blank, data_blank} = 2'h3;
    opt_byte = 8'h00;
    sp_set = 2'h0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd_exp(ADDR_SEC, 32'h0);
    rd_exp(8'h40, 32'h0);
    wr(ADDR_CMD, {28'h0, OP_SIG});
    for (int i = 0; i < 22; i++)
      rd_exp(ADDR_SIG, {23'h0, 1'b1, SIG[175-8*i -: 8]});
    rd_exp(ADDR_SIG, 32'h0);
    rd_exp(ADDR_ISTA, 32'h5);
    repeat (4) cmd_resp({28'h0, 4'h7 + 4'({$random(seed)} % 9)}, 32'h2);
    cmd_resp({28'h0, OP_GET}, 32'h1);
    wr(ADDR_IEN, 32'h2);
    rd_exp(ADDR_IEN, 32'h2);
    wr(ADDR_ICLR, 32'h7);
    cmd_resp(32'h0204, 32'h1);
    rd_exp(ADDR_SEC, 32'h2);
    check({31'h0, irq}, 32'h0);
    cmd_resp({28'h0, OP_WRITE}, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_ICLR, 32'h7);
    @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    cmd_resp({28'h0, OP_ERASE}, 32'h1);
    // Self-programming stand-in: let the fast oscillator settle; it owns no parity RAM
    repeat (OSC_WAIT) @(posedge clk_sys);
    sp_write_req <= 1'b1;
    @(posedge clk_sys);
    sp_write_req <= 1'b0;
    code_blank <= 1'b0;
    cmd_resp({28'h0, OP_REL}, 32'h2);
    code_blank <= 1'b1;
    cmd_resp({28'h0, OP_REL}, 32'h1);
    rd_exp(ADDR_SEC, 32'h6);
    check({31'h0, rel_pending}, 32'h1);
    check({30'h0, sec_state}, 32'h2);
    dev_reset();
    rd_exp(ADDR_SEC, 32'h0);
    check({31'h0, rel_pending}, 32'h0);
    opt_byte <= 8'h02;
    wr(ADDR_CTRL, 32'h1);
    rd_exp(ADDR_CTRL, 32'h1);
    rd_exp(ADDR_SEC, 32'h0);
    opt_byte <= 8'h03;
    repeat (2) @(posedge clk_sys);
    rd_exp(ADDR_SEC, 32'h8);
    check({31'h0, full_speed}, 32'h1);
    opt_byte <= 8'h00;
    sp_set <= 2'h1;
    @(posedge clk_sys);
    sp_set <= 2'h0;
    repeat (2) @(posedge clk_sys);
    rd_exp(ADDR_SEC, 32'h1);
    // Self erase stays allowed under erase prohibition
    sp_erase_req <= 1'b1;
    @(posedge clk_sys);
    sp_erase_req <= 1'b0;
    cmd_resp({28'h0, OP_ERASE}, 32'h2);
    cmd_resp({28'h0, OP_WRITE}, 32'h1);
    cmd_resp({28'h0, OP_REL}, 32'h2);
    dev_reset();
    rd_exp(ADDR_SEC, 32'h1);
    check({30'h0, sec_state}, 32'h1);
    check({31'h0, hresp}, 32'h0);
    check(32'(wcnt), 32'h2);
    check(32'(ecnt), 32'h2);
    conclude();
  end
endmodule // tb_flash_signature_security_gate
`default_nettype wire
